// ===== dv/mcg_ext_osc.sv
// partner: external crystal reference, swings only while enabled
`timescale 1ns/1ps
module mcg_ext_osc #(
  parameter realtime HALF_NS = 40.0
) (
  input wire logic run_i,
  input wire logic en_i,
  output logic ref_o
);
  // run_i low models a dead crystal; the line then stands still
  initial begin
    ref_o = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      if (run_i && en_i) ref_o = ~ref_o;
    end
  end
endmodule

// ===== dv/mcg_top_asserts.sv
// checker: port-level properties of the clock generator
`timescale 1ns/1ps
module mcg_top_asserts #(
  parameter int unsigned LOC_LOW_LIMIT = mcg_pkg::LOC_LOW_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  input wire mcg_pkg::mcg_bus_req_t bus_req_i,
  input wire logic [7:0] rdata_o,
  input wire logic stop_mode_i,
  input wire logic ext_ref_i,
  input wire logic internal_ref_clock_out_o,
  input wire logic external_ref_clock_out_o,
  input wire logic generator_output_clock_o,
  input wire logic bus_clk_en_o,
  input wire logic loop_enable_o,
  input wire logic ext_osc_enable_o,
  input wire logic chip_reset_req_o,
  input wire logic ref_fail_flag_o,
  input wire logic irq_o
);
  import mcg_pkg::*;
  logic [7:0] c1_r, c2_r, c3_r, c1_nxt, c2_nxt, c3_nxt;
  logic in_rst;
  //////////////////////////////////////////////////////////////////////////////
  // shadow of the control bytes, so gating is judged from bus traffic alone
  assign in_rst = !rst_b_i || !por_b_i;
  always_comb begin
    c1_nxt = (bus_req_i.wr && bus_req_i.addr == ADDR_CTRL1) ? bus_req_i.wdata : c1_r;
    c2_nxt = (bus_req_i.wr && bus_req_i.addr == ADDR_CTRL2) ? bus_req_i.wdata : c2_r;
    c3_nxt = (bus_req_i.wr && bus_req_i.addr == ADDR_CTRL3) ? bus_req_i.wdata : c3_r;
    if (in_rst) begin
      c1_nxt = RST_CTRL1;
      c2_nxt = RST_CTRL2;
      c3_nxt = RST_CTRL3;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    {c1_r, c2_r, c3_r} <= {c1_nxt, c2_nxt, c3_nxt};
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (in_rst);
  sequence loss_s;
    $rose(chip_reset_req_o);
  endsequence
  loop_on_a: assert property (loop_enable_o ==
    (!(c2_r[3] && c1_r[7:6] != 2'h0) && !stop_mode_i)) else $error("loop enable wrong");
  int_gate_a: assert property (internal_ref_clock_out_o |-> $past(c1_r[1]))
    else $error("internal ref out while disabled");
  int_stop_a: assert property ($rose(internal_ref_clock_out_o) && $past(stop_mode_i)
    && $past(stop_mode_i, 3) |-> $past(c1_r[0] && c1_r[1])) else $error("iref ran in stop");
  ext_gate_a: assert property (external_ref_clock_out_o |-> $past(c2_r[1]))
    else $error("external ref out while disabled");
  ext_keep_a: assert property (stop_mode_i && c2_r[1] && c2_r[0] |-> ext_osc_enable_o)
    else $error("external ref dropped in stop");
  bus_gen_a: assert property (bus_clk_en_o |-> generator_output_clock_o)
    else $error("bus enable without generator pulse");
  loss_arm_a: assert property (loss_s |-> $past(c3_r[5]))
    else $error("chip reset without armed monitor");
  loss_flag_a: assert property (loss_s |=> ref_fail_flag_o)
    else $error("reset cause flag not set");
  flag_hold_a: assert property (disable iff (!por_b_i)
    $fell(ref_fail_flag_o) |-> $past(!por_b_i)) else $error("flag lost without power-on");
  rd_idle_a: assert property (!$past(bus_req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule
bind mcg_top mcg_top_asserts #(.LOC_LOW_LIMIT(LOC_LOW_LIMIT)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i), .bus_req_i(bus_req_i),
  .rdata_o(rdata_o), .stop_mode_i(stop_mode_i), .ext_ref_i(ext_ref_i),
  .internal_ref_clock_out_o(internal_ref_clock_out_o),
  .external_ref_clock_out_o(external_ref_clock_out_o),
  .generator_output_clock_o(generator_output_clock_o), .bus_clk_en_o(bus_clk_en_o),
  .loop_enable_o(loop_enable_o), .ext_osc_enable_o(ext_osc_enable_o),
  .chip_reset_req_o(chip_reset_req_o), .ref_fail_flag_o(ref_fail_flag_o), .irq_o(irq_o));

// ===== dv/mcg_top_test.sv
// testbench: registers, gating, trim, divider, lock loss and clock monitor
`timescale 1ns/1ps
module mcg_top_test;
  import mcg_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic por_b_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic osc_run = 1'b1;
  mcg_bus_req_t req = '0;
  logic [7:0] rdata;
  logic ext_ref, iro, ero, gen, bce, lpe, oscen, crr, rff, irq;
  logic [7:0] trims [2] = '{8'h08, 8'h20};
  logic [7:0] c2v [3] = '{8'h03, 8'h02, 8'h01};
  logic oke [3] = '{1'b1, 1'b0, 1'b0};
  int fails = 0;
  int num_checks = 0;
  int n;
  mcg_top #(.LOC_LOW_LIMIT(300)) dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i), .bus_req_i(req),
    .rdata_o(rdata), .stop_mode_i(stop_mode_i), .ext_ref_i(ext_ref),
    .internal_ref_clock_out_o(iro), .external_ref_clock_out_o(ero),
    .generator_output_clock_o(gen), .bus_clk_en_o(bce), .loop_enable_o(lpe),
    .ext_osc_enable_o(oscen), .chip_reset_req_o(crr), .ref_fail_flag_o(rff), .irq_o(irq));
  mcg_ext_osc u_osc (.run_i(osc_run), .en_i(oscen), .ref_o(ext_ref));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string s, input logic [15:0] v, input logic [15:0] e);
    num_checks++;
    if (v !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clk_sys_i);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    req.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), 16'(rdata & m), 16'(e));
  endtask
  function automatic logic sg(input int w);
    case (w)
      0: return gen;
      1: return bce;
      2: return iro;
      default: return ero;
    endcase
  endfunction
  // cycles between two rising edges; 0 when fewer than two are seen
  task automatic iv(input int w, output int n);
    int k;
    int g;
    logic p;
    n = 0;
    k = 0;
    g = 0;
    p = 1'b1;
    while (k < 2 && g < 1500) begin
      @(posedge clk_sys_i);
      #1;
      g++;
      if (k == 1) n++;
      if (sg(w) === 1'b1 && p !== 1'b1) k++;
      p = sg(w);
    end
    if (k < 2) n = 0;
  endtask
  task automatic pulse_rst(input logic por);
    @(posedge clk_sys_i);
    if (por) por_b_i <= 1'b0;
    else rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    por_b_i <= 1'b1;
    rst_b_i <= 1'b1;
    osc_run <= 1'b1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #300_000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    por_b_i <= 1'b1;
    rd(ADDR_CTRL1, RST_CTRL1);
    rd(ADDR_CTRL2, RST_CTRL2);
    rd(ADDR_TRIM, RST_TRIM);
    rd(ADDR_CTRL3, RST_CTRL3);
    rd(ADDR_IRQ_MASK, 8'h00);
    wr(8'h4d, 8'h5a);
    rd(8'h4d, 8'h00);
    $display("test registers done");
    foreach (trims[i]) begin
      wr(ADDR_TRIM, trims[i]);
      wr(ADDR_CTRL1, 8'h46);
      iv(2, n);
      chk("iref period", 16'(n), 16'(2 * (IREF_BASE_CYC + 2 * trims[i])));
      iv(0, n);
      chk("gen internal", 16'(n), 16'(IREF_BASE_CYC + 2 * trims[i]));
      wr(ADDR_CTRL1, 8'h80);
      iv(0, n);
      chk("gen external", 16'(n), 16'h0008);
    end
    wr(ADDR_CTRL1, 8'h04);
    iv(2, n);
    chk("iref gated", 16'(n), 16'h0000);
    $display("test trim done");
    @(posedge clk_sys_i);
    stop_mode_i <= 1'b1;
    wr(ADDR_CTRL1, 8'h06);
    iv(2, n);
    chk("iref stop off", 16'(n), 16'h0000);
    wr(ADDR_CTRL1, 8'h07);
    iv(2, n);
    chk("iref stop on", 16'(n), 16'(2 * (IREF_BASE_CYC + 2 * trims[1])));
    foreach (c2v[i]) begin
      wr(ADDR_CTRL2, c2v[i]);
      chk("osc keep", 16'(oscen), 16'(oke[i]));
    end
    wr(ADDR_CTRL1, 8'h80);
    // the mode register follows the control byte one cycle later
    @(posedge clk_sys_i);
    #1 chk("osc mode keep", 16'(oscen), 16'h0001);
    @(posedge clk_sys_i);
    stop_mode_i <= 1'b0;
    $display("test stop done");
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_CTRL2, 8'(b << 6));
      iv(1, n);
      iv(1, n);
      chk("bus divider", 16'(n), 16'(8 << b));
    end
    wr(ADDR_CTRL2, 8'h08);
    chk("loop bypass", 16'(lpe), 16'h0000);
    wr(ADDR_CTRL2, 8'h02);
    chk("loop kept", 16'(lpe), 16'h0001);
    iv(3, n);
    chk("ext out", 16'(n), 16'h0008);
    wr(ADDR_CTRL2, 8'h00);
    iv(3, n);
    chk("ext gated", 16'(n), 16'h0000);
    // engaged external modes feed the generator through the reference divider
    wr(ADDR_CTRL1, 8'h08);
    wr(ADDR_CTRL3, 8'h41);
    iv(0, n);
    chk("gen pll divided", 16'(n), 16'h0010);
    wr(ADDR_CTRL3, 8'h01);
    wr(ADDR_CTRL2, 8'h08);
    wr(ADDR_CTRL1, 8'h44);
    chk("loop lowpower", 16'(lpe), 16'h0000);
    iv(0, n);
    chk("gen lowpower int", 16'(n), 16'(IREF_BASE_CYC + 2 * trims[1]));
    wr(ADDR_CTRL2, 8'h00);
    $display("test divider done");
    // external crystal is off here, so lock can only come from the internal ref
    wr(ADDR_TRIM, 8'h08);
    wr(ADDR_CTRL1, 8'h04);
    repeat (3500) @(posedge clk_sys_i);
    // lock-lost flag stays set from the reprogramming of a locked loop
    rd(ADDR_STATE, 8'hd0, 8'hf0);
    wr(ADDR_CTRL3, 8'h91);
    rd(ADDR_CTRL3, 8'h81);
    chk("irq lock lost", 16'(irq), 16'h0001);
    rd(ADDR_STATE, 8'h80, 8'h80);
    wr(ADDR_STATE, 8'h80);
    chk("irq lock lost clear", 16'(irq), 16'h0000);
    $display("test lock done");
    wr(ADDR_CTRL3, 8'h21);
    wr(ADDR_CTRL2, 8'h02);
    repeat (400) @(posedge clk_sys_i);
    chk("no false loss", 16'(crr), 16'h0000);
    @(posedge clk_sys_i);
    osc_run <= 1'b0;
    repeat (400) @(posedge clk_sys_i);
    #1 chk("loss reset", 16'(crr), 16'h0001);
    chk("cause flag", 16'(rff), 16'h0001);
    chk("irq masked", 16'(irq), 16'h0000);
    wr(ADDR_IRQ_MASK, 8'h04);
    chk("irq raised", 16'(irq), 16'h0001);
    rd(ADDR_IRQ_STATUS, 8'h04, 8'h04);
    chk("irq cleared", 16'(irq), 16'h0000);
    $display("test monitor done");
    wr(ADDR_TRIM, 8'h10);
    pulse_rst(1'b0);
    rd(ADDR_TRIM, 8'h10);
    chk("flag kept", 16'(rff), 16'h0001);
    chk("reset req cleared", 16'(crr), 16'h0000);
    pulse_rst(1'b1);
    rd(ADDR_TRIM, RST_TRIM);
    chk("flag por", 16'(rff), 16'h0000);
    $display("test resets done");
    print_verdict();
  end
endmodule

// ===== src/mcg_pkg.sv
// package: register map, field layouts, modes and timing of the clock generator
package mcg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL1 = 8'h48;
  localparam logic [7:0] ADDR_CTRL2 = 8'h49;
  localparam logic [7:0] ADDR_TRIM = 8'h4a;
  localparam logic [7:0] ADDR_STATE = 8'h4b;
  localparam logic [7:0] ADDR_CTRL3 = 8'h4c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h50;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h51;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_CTRL1 = 8'h04;
  localparam logic [7:0] RST_CTRL2 = 8'h40;
  localparam logic [7:0] RST_TRIM = 8'h80;
  localparam logic RST_FINE_ADJ = 1'b0;
  localparam logic [7:0] RST_CTRL3 = 8'h01;
  localparam logic [2:0] RST_IRQ = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and encodings
  localparam int STATE_LOCK_LOST = 7;
  localparam int STATE_FINE_ADJ = 0;
  localparam int IRQ_LOCK_LOST = 0;
  localparam int IRQ_LOCKED = 1;
  localparam int IRQ_EXT_LOSS = 2;
  localparam logic [1:0] CLKS_LOOP = 2'h0;
  localparam logic [1:0] CLKS_INT = 2'h1;
  localparam logic [1:0] CLKS_EXT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 100;
  localparam logic [9:0] IREF_BASE_CYC = 10'h040;
  localparam logic [7:0] LOCK_REF_TICKS = 8'h20;
  localparam int LOC_HIGH_US = 2;
  localparam int LOC_LOW_US = 100;
  localparam int LOC_HIGH_CYC = LOC_HIGH_US * CLK_MHZ;
  localparam int LOC_LOW_CYC = LOC_LOW_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [7:0] {
    md_fll_engaged_internal = 8'b0000_0001,
    md_fll_engaged_external = 8'b0000_0010,
    md_fll_bypassed_internal = 8'b0000_0100,
    md_fll_bypassed_external = 8'b0000_1000,
    md_pll_engaged_external = 8'b0001_0000,
    md_pll_bypassed_external = 8'b0010_0000,
    md_bypassed_lowpower_internal = 8'b0100_0000,
    md_bypassed_lowpower_external = 8'b1000_0000
  } mcg_mode_t;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] ref_divider;
    logic internal_ref_select;
    logic int_ref_out_enable;
    logic int_ref_stop_enable;
  } mcg_ctrl1_t;

  typedef struct packed {
    logic [1:0] bus_divider;
    logic freq_range;
    logic high_gain;
    logic low_power_bypass;
    logic ext_ref_select;
    logic ext_ref_out_enable;
    logic ext_ref_stop_enable;
  } mcg_ctrl2_t;

  typedef struct packed {
    logic lock_lost_irq_enable;
    logic pll_select;
    logic ext_clock_watch_enable;
    logic zero;
    logic [3:0] vco_divider;
  } mcg_ctrl3_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcg_bus_req_t;

endpackage

// ===== src/mcg_top.sv
// clock generator: reference selection, trim, bus divider, clock monitor
//
// Notes on behaviour
// - bus divider change takes effect immediately
// - low-power bypass stops loop unless loop clock selected; stop mode also stops it
// - internal ref output only while enabled
// - larger trim code gives longer internal period
// - trim reaches generator output only in internal modes, internal ref output in any mode
// - trim fields reset by power-on only
// - internal ref runs in stop if both set
// - external ref output only while enabled
// - internal select keeps external out of loop
// - external ref kept in stop by enables/modes
// - armed monitor resets chip on reference loss
// - reference loss sets reset cause flag
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module mcg_top #(
  parameter int unsigned LOC_LOW_LIMIT = mcg_pkg::LOC_LOW_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  input wire mcg_pkg::mcg_bus_req_t bus_req_i,
  output logic [7:0] rdata_o,
  input wire logic stop_mode_i,
  input wire logic ext_ref_i,
  output logic internal_ref_clock_out_o,
  output logic external_ref_clock_out_o,
  output logic generator_output_clock_o,
  output logic bus_clk_en_o,
  output logic loop_enable_o,
  output logic ext_osc_enable_o,
  output logic chip_reset_req_o,
  output logic ref_fail_flag_o,
  output logic irq_o
);
  import mcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic mcg_mode_t mode_decode(input mcg_ctrl1_t c1, input mcg_ctrl2_t c2,
                                            input mcg_ctrl3_t c3);
    case (c1.clk_sel)
      CLKS_LOOP: begin
        if (c3.pll_select) mode_decode = md_pll_engaged_external;
        else if (c1.internal_ref_select) mode_decode = md_fll_engaged_internal;
        else mode_decode = md_fll_engaged_external;
      end
      CLKS_INT: begin
        if (c2.low_power_bypass) mode_decode = md_bypassed_lowpower_internal;
        else mode_decode = md_fll_bypassed_internal;
      end
      CLKS_EXT: begin
        if (c2.low_power_bypass) mode_decode = md_bypassed_lowpower_external;
        else if (c3.pll_select) mode_decode = md_pll_bypassed_external;
        else mode_decode = md_fll_bypassed_external;
      end
      default: mode_decode = md_fll_engaged_internal;
    endcase
  endfunction

  function automatic logic ext_mode(input mcg_mode_t m);
    case (m)
      md_fll_engaged_external, md_fll_bypassed_external, md_pll_engaged_external,
      md_pll_bypassed_external, md_bypassed_lowpower_external: ext_mode = 1'b1;
      default: ext_mode = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic any_rst_b;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic ext_edge;
  mcg_ctrl1_t c1_r, c1_nxt;
  mcg_ctrl2_t c2_r, c2_nxt;
  mcg_ctrl3_t c3_r, c3_nxt;
  logic [7:0] trm_r, trm_nxt;
  logic fine_adj_r, fine_adj_nxt;
  logic ref_fail_r, ref_fail_nxt;
  logic lock_lost_r, lock_lost_nxt;
  logic [2:0] irq_st_r, irq_st_nxt;
  logic [2:0] irq_msk_r, irq_msk_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [1:0] clkst_r, clkst_nxt;
  mcg_mode_t mode_r, mode_nxt;
  logic [9:0] iref_cnt_r, iref_cnt_nxt;
  logic iref_lvl_r, iref_lvl_nxt;
  logic [7:0] refd_cnt_r, refd_cnt_nxt;
  logic [7:0] lock_cnt_r, lock_cnt_nxt;
  logic lock_r, lock_nxt;
  logic [15:0] loc_cnt_r, loc_cnt_nxt;
  logic osc_ok_r, osc_ok_nxt;
  logic [2:0] bus_cnt_r, bus_cnt_nxt;
  logic reset_req_r, reset_req_nxt;
  logic iclk_out_r, iclk_out_nxt;
  logic eclk_out_r, eclk_out_nxt;
  logic gen_r, gen_nxt;
  logic bus_en_r, bus_en_nxt;
  logic [9:0] iref_period;
  logic iref_run, iref_tick;
  logic ext_on, ext_div_pulse, loop_ref_pulse;
  logic loop_on, cfg_wr, lock_lost_evt, locked_evt;
  logic [15:0] loc_limit;
  logic ext_stale;
  logic gen_pulse;
  logic [7:0] refd_limit;
  logic [2:0] bus_limit;

  assign any_rst_b = rst_b_i & por_b_i;

  ////////////////////////////////////////////////////////////////////////////
  // external reference pin synchroniser; edge taken past the second stage
  always_ff @(posedge clk_sys_i) begin
    if (!any_rst_b) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_ref_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_edge = ext_s2_r & ~ext_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // reference and loop control
  always_comb begin
    iref_period = IREF_BASE_CYC + {1'b0, trm_r, fine_adj_r};
    iref_run = ~stop_mode_i | (c1_r.int_ref_stop_enable & c1_r.int_ref_out_enable);
    iref_tick = iref_run & (iref_cnt_r >= iref_period - 10'h001);
    if (stop_mode_i) begin
      ext_on = (c2_r.ext_ref_stop_enable & c2_r.ext_ref_out_enable) | ext_mode(mode_r);
    end else begin
      ext_on = c2_r.ext_ref_select | c2_r.ext_ref_out_enable | ext_mode(mode_r);
    end
    refd_limit = 8'((8'h01 << c1_r.ref_divider) - 8'h01);
    // external edges reach the loop only while the internal ref is not selected
    ext_div_pulse = ext_on & ext_edge & ~c1_r.internal_ref_select &
                    (refd_cnt_r >= refd_limit);
    loop_ref_pulse = c1_r.internal_ref_select ? iref_tick : ext_div_pulse;
    loop_on = ~(c2_r.low_power_bypass & (c1_r.clk_sel != CLKS_LOOP)) & ~stop_mode_i;
    cfg_wr = bus_req_i.wr & ((bus_req_i.addr == ADDR_CTRL1) | (bus_req_i.addr == ADDR_CTRL3));
    loc_limit = c2_r.freq_range ? 16'(LOC_HIGH_CYC) : 16'(LOC_LOW_LIMIT);
    ext_stale = loc_cnt_r >= loc_limit;
    // trim only reaches the output through the internal tick
    case (mode_r)
      md_fll_engaged_internal: gen_pulse = iref_tick;
      md_fll_bypassed_internal, md_bypassed_lowpower_internal: gen_pulse = iref_tick;
      md_fll_engaged_external, md_pll_engaged_external: gen_pulse = ext_div_pulse;
      md_fll_bypassed_external, md_pll_bypassed_external,
      md_bypassed_lowpower_external: gen_pulse = ext_on & ext_edge;
      default: gen_pulse = 1'b0;
    endcase
    bus_limit = 3'((3'h1 << c2_r.bus_divider) - 3'h1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing state next values
  always_comb begin
    mode_nxt = mode_decode(c1_r, c2_r, c3_r);
    clkst_nxt = c1_r.clk_sel;
    iref_cnt_nxt = iref_cnt_r;
    iref_lvl_nxt = iref_lvl_r;
    if (iref_tick) begin
      iref_cnt_nxt = 10'h000;
      iref_lvl_nxt = ~iref_lvl_r;
    end else if (iref_run) begin
      iref_cnt_nxt = iref_cnt_r + 10'h001;
    end
    refd_cnt_nxt = refd_cnt_r;
    if (!ext_on || c1_r.internal_ref_select) refd_cnt_nxt = 8'h00;
    else if (ext_edge) refd_cnt_nxt = (refd_cnt_r >= refd_limit) ? 8'h00 : refd_cnt_r + 8'h01;
    // lock restarts on loop stop, reference reprogramming or a stale reference
    lock_cnt_nxt = lock_cnt_r;
    if (!loop_on || cfg_wr || (!c1_r.internal_ref_select && ext_stale)) begin
      lock_cnt_nxt = 8'h00;
    end else if (loop_ref_pulse && lock_cnt_r < LOCK_REF_TICKS) begin
      lock_cnt_nxt = lock_cnt_r + 8'h01;
    end
    lock_nxt = lock_cnt_nxt == LOCK_REF_TICKS;
    lock_lost_evt = lock_r & ~lock_nxt & loop_on;
    locked_evt = ~lock_r & lock_nxt;
    // monitor counts cycles since the last external edge, saturating
    loc_cnt_nxt = loc_cnt_r;
    if (!ext_on || ext_edge) loc_cnt_nxt = 16'h0000;
    else if (!ext_stale) loc_cnt_nxt = loc_cnt_r + 16'h0001;
    osc_ok_nxt = osc_ok_r;
    if (!ext_on || ext_stale) osc_ok_nxt = 1'b0;
    else if (ext_edge) osc_ok_nxt = 1'b1;
    // held until the chip reset it asks for arrives
    reset_req_nxt = reset_req_r | (c3_r.ext_clock_watch_enable & ext_on & ext_stale);
    // live divider limit: a new setting applies on the next source pulse
    bus_cnt_nxt = bus_cnt_r;
    bus_en_nxt = 1'b0;
    if (gen_pulse) begin
      if (bus_cnt_r >= bus_limit) begin
        bus_cnt_nxt = 3'h0;
        bus_en_nxt = 1'b1;
      end else begin
        bus_cnt_nxt = bus_cnt_r + 3'h1;
      end
    end
    gen_nxt = gen_pulse;
    iclk_out_nxt = iref_lvl_nxt & c1_r.int_ref_out_enable & iref_run;
    eclk_out_nxt = ext_s2_r & c2_r.ext_ref_out_enable & ext_on;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!any_rst_b) begin
      mode_r <= md_fll_engaged_internal;
      clkst_r <= CLKS_LOOP;
      iref_cnt_r <= 10'h000;
      iref_lvl_r <= 1'b0;
      refd_cnt_r <= 8'h00;
      lock_cnt_r <= 8'h00;
      lock_r <= 1'b0;
      loc_cnt_r <= 16'h0000;
      osc_ok_r <= 1'b0;
      reset_req_r <= 1'b0;
      bus_cnt_r <= 3'h0;
      bus_en_r <= 1'b0;
      gen_r <= 1'b0;
      iclk_out_r <= 1'b0;
      eclk_out_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      clkst_r <= clkst_nxt;
      iref_cnt_r <= iref_cnt_nxt;
      iref_lvl_r <= iref_lvl_nxt;
      refd_cnt_r <= refd_cnt_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      lock_r <= lock_nxt;
      loc_cnt_r <= loc_cnt_nxt;
      osc_ok_r <= osc_ok_nxt;
      reset_req_r <= reset_req_nxt;
      bus_cnt_r <= bus_cnt_nxt;
      bus_en_r <= bus_en_nxt;
      gen_r <= gen_nxt;
      iclk_out_r <= iclk_out_nxt;
      eclk_out_r <= eclk_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on-only state: trim and reset cause survive other resets
  always_comb begin
    trm_nxt = trm_r;
    fine_adj_nxt = fine_adj_r;
    if (bus_req_i.wr && bus_req_i.addr == ADDR_TRIM) trm_nxt = bus_req_i.wdata;
    if (bus_req_i.wr && bus_req_i.addr == ADDR_STATE) begin
      fine_adj_nxt = bus_req_i.wdata[STATE_FINE_ADJ];
    end
    ref_fail_nxt = ref_fail_r | reset_req_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!por_b_i) begin
      trm_r <= RST_TRIM;
      fine_adj_r <= RST_FINE_ADJ;
      ref_fail_r <= 1'b0;
    end else begin
      trm_r <= trm_nxt;
      fine_adj_r <= fine_adj_nxt;
      ref_fail_r <= ref_fail_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    c1_nxt = c1_r;
    c2_nxt = c2_r;
    c3_nxt = c3_r;
    irq_msk_nxt = irq_msk_r;
    lock_lost_nxt = lock_lost_r;
    irq_st_nxt = irq_st_r;
    rdata_nxt = 8'h00;
    if (bus_req_i.wr) begin
      case (bus_req_i.addr)
        ADDR_CTRL1: c1_nxt = mcg_ctrl1_t'(bus_req_i.wdata);
        ADDR_CTRL2: c2_nxt = mcg_ctrl2_t'(bus_req_i.wdata);
        ADDR_CTRL3: c3_nxt = mcg_ctrl3_t'({bus_req_i.wdata[7:5], 1'b0, bus_req_i.wdata[3:0]});
        ADDR_STATE: if (bus_req_i.wdata[STATE_LOCK_LOST]) lock_lost_nxt = 1'b0;
        ADDR_IRQ_MASK: irq_msk_nxt = bus_req_i.wdata[2:0];
        default: ;
      endcase
    end
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        ADDR_CTRL1: rdata_nxt = c1_r;
        ADDR_CTRL2: rdata_nxt = c2_r;
        ADDR_TRIM: rdata_nxt = trm_r;
        ADDR_STATE: rdata_nxt = {lock_lost_r, lock_r, c3_r.pll_select,
                                 c1_r.internal_ref_select, clkst_r, osc_ok_r, fine_adj_r};
        ADDR_CTRL3: rdata_nxt = c3_r;
        ADDR_IRQ_STATUS: rdata_nxt = {5'h00, irq_st_r};
        ADDR_IRQ_MASK: rdata_nxt = {5'h00, irq_msk_r};
        default: rdata_nxt = 8'h00;
      endcase
      if (bus_req_i.addr == ADDR_IRQ_STATUS) irq_st_nxt = 3'h0;
    end
    // a new event in the clearing cycle stays set
    if (lock_lost_evt) lock_lost_nxt = 1'b1;
    irq_st_nxt[IRQ_LOCK_LOST] = irq_st_nxt[IRQ_LOCK_LOST] | lock_lost_evt;
    irq_st_nxt[IRQ_LOCKED] = irq_st_nxt[IRQ_LOCKED] | locked_evt;
    irq_st_nxt[IRQ_EXT_LOSS] = irq_st_nxt[IRQ_EXT_LOSS] | (reset_req_nxt & ~reset_req_r);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!any_rst_b) begin
      c1_r <= mcg_ctrl1_t'(RST_CTRL1);
      c2_r <= mcg_ctrl2_t'(RST_CTRL2);
      c3_r <= mcg_ctrl3_t'(RST_CTRL3);
      irq_msk_r <= RST_IRQ;
      irq_st_r <= RST_IRQ;
      lock_lost_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
      c3_r <= c3_nxt;
      irq_msk_r <= irq_msk_nxt;
      irq_st_r <= irq_st_nxt;
      lock_lost_r <= lock_lost_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o = rdata_r;
  assign internal_ref_clock_out_o = iclk_out_r;
  assign external_ref_clock_out_o = eclk_out_r;
  assign generator_output_clock_o = gen_r;
  assign bus_clk_en_o = bus_en_r;
  assign loop_enable_o = loop_on;
  assign ext_osc_enable_o = ext_on;
  assign chip_reset_req_o = reset_req_r;
  assign ref_fail_flag_o = ref_fail_r;
  assign irq_o = (|(irq_st_r & irq_msk_r)) | (lock_lost_r & c3_r.lock_lost_irq_enable);

endmodule
